//--- hdl/spf_framer.sv
// Serial pause detector, command framing and one-kilobyte radio transmit buffer.
module spf_framer import spf_pkg::*; #(
  parameter int CAP_CYCLES = PAUSE_CAP_CYC,
  parameter int PRE_CYCLES = PREAMBLE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_tx_data_line,
  input wire spf_char_s char_in,
  input wire spf_cfg_s cfg,
  input wire logic radio_rx_busy,
  input wire logic radio_ready,
  output spf_char_s radio_out,
  output logic radio_tx_on,
  output logic cts,
  output logic pause_det,
  output logic cmd_mode,
  output logic cmd_ok,
  output logic config_command_start,
  output logic addr_start_seen,
  output logic overfill_restart
);

  // ----------------------------------------------------------------
  // Pause timer
  // ----------------------------------------------------------------
  logic line_q;
  logic [15:0] bit_cyc_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] chr_cnt_q;
  logic [23:0] abs_q;
  logic pause_q;
  logic seen_pause_q;

  wire line_edge = serial_tx_data_line != line_q;
  wire bit_tick = bit_cyc_q >= cfg.bit_cycles - CYC_ONE;
  wire chr_tick = bit_tick && (bit_cnt_q >= cfg.frame_bits - BITS_ONE);
  wire [7:0] thr = (cfg.pause_chars < PAUSE_MIN) ? PAUSE_MIN : cfg.pause_chars;
  wire cap_hit = abs_q >= 24'(CAP_CYCLES - 1);
  wire pause_hit = (chr_cnt_q >= thr) || cap_hit;
  wire chr_sat = chr_cnt_q == CHR_SAT;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_q <= 1'b1;
    end else begin
      line_q <= serial_tx_data_line;
    end
  end

  // A character time is frame_bits periods of bit_cycles clocks.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cyc_q <= '0;
      bit_cnt_q <= '0;
    end else if (line_edge) begin
      bit_cyc_q <= '0;
      bit_cnt_q <= '0;
    end else if (chr_tick) begin
      bit_cyc_q <= '0;
      bit_cnt_q <= '0;
    end else if (bit_tick) begin
      bit_cyc_q <= '0;
      bit_cnt_q <= bit_cnt_q + BITS_ONE;
    end else begin
      bit_cyc_q <= bit_cyc_q + CYC_ONE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chr_cnt_q <= '0;
      abs_q <= '0;
      pause_q <= 1'b0;
    end else if (line_edge) begin
      chr_cnt_q <= '0;
      abs_q <= '0;
      pause_q <= 1'b0;
    end else begin
      if (chr_tick && !chr_sat) begin
        chr_cnt_q <= chr_cnt_q + 8'h01;
      end
      if (!cap_hit) begin
        abs_q <= abs_q + 24'h000001;
      end
      // The absolute cap keeps slow baud rates from stalling the link.
      pause_q <= pause_hit;
    end
  end

  // Remembers that the line went quiet since the last character arrived.
  // A character consumes the pause, so a back-to-back follower never counts as leading.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_pause_q <= 1'b1;
    end else if (char_in.valid) begin
      seen_pause_q <= 1'b0;
    end else if (pause_q) begin
      seen_pause_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Character classification
  // ----------------------------------------------------------------
  logic [1:0] esc_cnt_q;
  logic esc_minus_q;
  logic cmd_mode_q;

  wire lead_ok = char_in.valid && (seen_pause_q || pause_q);
  wire is_plus = char_in.data == CHR_PLUS;
  wire is_minus = char_in.data == CHR_MINUS;
  wire is_esc = lead_ok && (cmd_mode_q ? is_minus : is_plus);
  wire esc_done = is_esc && (esc_cnt_q == ESC_COUNT - 2'h1);
  wire cfg_start = lead_ok && cfg.cfg_cmd_en && (char_in.data == CFG_LEAD_CHR);
  wire addr_hit = lead_ok && (char_in.data == cfg.addr_char);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      esc_cnt_q <= '0;
      esc_minus_q <= 1'b0;
    end else if (char_in.valid) begin
      esc_minus_q <= cmd_mode_q;
      if (esc_done || !is_esc) begin
        esc_cnt_q <= '0;
      end else begin
        esc_cnt_q <= esc_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_mode_q <= 1'b0;
      cmd_ok <= 1'b0;
      config_command_start <= 1'b0;
      addr_start_seen <= 1'b0;
    end else begin
      if (esc_done) begin
        cmd_mode_q <= !cmd_mode_q;
      end
      cmd_ok <= esc_done;
      config_command_start <= cfg_start || (lead_ok && cmd_mode_q);
      addr_start_seen <= addr_hit && !cmd_mode_q;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  logic [7:0] mem [BUF_DEPTH];
  logic [BUF_AW-1:0] wr_q;
  logic [BUF_AW-1:0] rd_q;
  logic [BUF_AW:0] cnt_q;
  spf_state_e state_q;
  spf_state_e state_d;
  logic [23:0] pre_q;
  logic cts_q;

  // Command-mode traffic never reaches the air; escape and config lead characters
  // still go out while not in command mode, since they look like user data.
  wire push_req = char_in.valid && !cmd_mode_q;
  wire buf_full = cnt_q == BUF_FULL_LVL;
  wire overfill = push_req && buf_full;
  wire push = push_req && !buf_full;
  wire buf_empty = cnt_q == '0;
  wire out_free = !radio_out.valid || radio_ready;
  wire pop = (state_q == SPF_SEND) && out_free && !buf_empty && !overfill;
  wire pre_done = pre_q >= 24'(PRE_CYCLES - 1);

  // Writes land even during reception or preamble.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= char_in.data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (overfill) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 10'h001;
      end
      if (pop) begin
        rd_q <= rd_q + 10'h001;
      end
      cnt_q <= cnt_q + 11'(push) - 11'(pop);
    end
  end

  // ----------------------------------------------------------------
  // Radio transmit sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SPF_LISTEN: begin
        // Waiting on the channel keeps queued bytes until it frees.
        if (!buf_empty && !radio_rx_busy && !cmd_mode_q) begin
          state_d = SPF_PREAMBLE;
        end
      end
      SPF_PREAMBLE: begin
        if (pre_done) begin
          state_d = SPF_SEND;
        end
      end
      SPF_SEND: begin
        if (buf_empty && !radio_out.valid && pause_q) begin
          state_d = SPF_LISTEN;
        end
      end
      default: begin
        state_d = SPF_LISTEN;
      end
    endcase
    if (overfill && state_q != SPF_LISTEN) begin
      state_d = SPF_PREAMBLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SPF_LISTEN;
      pre_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != SPF_PREAMBLE || state_q != SPF_PREAMBLE) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + 24'h000001;
      end
    end
  end

  // Restarting drops any byte that was waiting at the radio.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_out <= '0;
    end else if (overfill) begin
      radio_out <= '0;
    end else if (pop) begin
      radio_out <= '{valid: 1'b1, data: mem[rd_q]};
    end else if (radio_ready) begin
      radio_out.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flow control and status
  // ----------------------------------------------------------------
  // Headroom absorbs bytes already in flight when the terminal sees CTS drop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_q <= 1'b1;
    end else begin
      cts_q <= (cnt_q + 11'(push) - 11'(pop)) < CTS_OFF_LVL;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_tx_on <= 1'b0;
      overfill_restart <= 1'b0;
      pause_det <= 1'b0;
      cmd_mode <= 1'b0;
    end else begin
      radio_tx_on <= state_d != SPF_LISTEN;
      overfill_restart <= overfill;
      pause_det <= pause_q;
      cmd_mode <= cmd_mode_q;
    end
  end

  assign cts = cts_q;

  // Kept for readability of waveforms only; it drives no output.
  wire unused_ok = esc_minus_q;

endmodule : spf_framer

//--- shared/spf_pkg.sv
// Constants and carrier types for the serial pause framer and transmit buffer.
// Functional notes
// - A span with no transitions on the serial data line counts as a pause.
// - Radio transmission ends only when the buffer is empty and a pause is seen.
// - A config command is accepted only right after a pause; terminal must idle first.
// - A user address start character counts only if a pause precedes it.
// - Pause threshold is 3 to 255 character times, default 3.
// - One character time is frame bit count times one bit period.
// - Pause detection time never exceeds 170 ms.
// - In data mode, terminal data starts a radio transmission.
// - Each transmission begins with a preamble; data arriving meanwhile is buffered.
// - Buffer holds 1 kB; transmitter stays on until buffer drains.
// - Terminal obeys CTS; on overfill the buffer is discarded and transmission restarts.
// - Serial data arriving during radio reception goes into the buffer.
// - Data buffered during reception is sent as soon as the channel frees.
// - Three pluses spaced by pauses enter command mode, three minuses leave; OK answers.
package spf_pkg;

  localparam int CLK_KHZ = 50000;
  localparam int PAUSE_CAP_MS = 170;
  localparam int PAUSE_CAP_CYC = PAUSE_CAP_MS * CLK_KHZ;
  localparam int PREAMBLE_US = 2000;
  localparam int PREAMBLE_CYC = PREAMBLE_US * (CLK_KHZ / 1000);

  localparam int BUF_DEPTH = 1024;
  localparam int BUF_AW = 10;
  localparam int CTS_HEADROOM = 16;
  localparam logic [BUF_AW:0] CTS_OFF_LVL = 11'(BUF_DEPTH - CTS_HEADROOM);
  localparam logic [BUF_AW:0] BUF_FULL_LVL = 11'(BUF_DEPTH);

  localparam logic [7:0] PAUSE_MIN = 8'h03;
  localparam logic [7:0] PAUSE_DEF = 8'h03;
  localparam logic [7:0] CHR_PLUS = 8'h2b;
  localparam logic [7:0] CHR_MINUS = 8'h2d;
  localparam logic [7:0] CFG_LEAD_CHR = 8'h53;
  localparam logic [1:0] ESC_COUNT = 2'h3;
  localparam logic [7:0] CHR_SAT = 8'hff;
  localparam logic [15:0] CYC_ONE = 16'h0001;
  localparam logic [3:0] BITS_ONE = 4'h1;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spf_char_s;

  typedef struct packed {
    logic [7:0] pause_chars;
    logic [3:0] frame_bits;
    logic [15:0] bit_cycles;
    logic [7:0] addr_char;
    logic cfg_cmd_en;
  } spf_cfg_s;

  typedef enum logic [1:0] {
    SPF_LISTEN,
    SPF_PREAMBLE,
    SPF_SEND
  } spf_state_e;

endpackage : spf_pkg

//--- verif/spf_framer_sva.sv
// Port assertions for the pause framer.
module spf_framer_sva import spf_pkg::*; #(
  parameter int CAP_CYCLES = PAUSE_CAP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_tx_data_line,
  input wire spf_char_s char_in,
  input wire spf_cfg_s cfg,
  input wire logic radio_rx_busy,
  input wire logic radio_ready,
  input wire spf_char_s radio_out,
  input wire logic radio_tx_on,
  input wire logic cts,
  input wire logic pause_det,
  input wire logic cmd_mode,
  input wire logic cmd_ok,
  input wire logic config_command_start,
  input wire logic addr_start_seen,
  input wire logic overfill_restart
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic line_q;
  int quiet_q;
  int thr;
  int lim;
  // Quiet time is counted apart from the design so that threshold and cap are checked to within four cycles.
  assign thr = int'(cfg.pause_chars < PAUSE_MIN ? PAUSE_MIN : cfg.pause_chars) * int'(cfg.frame_bits)
    * int'(cfg.bit_cycles);
  assign lim = thr < CAP_CYCLES ? thr : CAP_CYCLES;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_q <= 1'b1;
      quiet_q <= 0;
    end else begin
      line_q <= serial_tx_data_line;
      quiet_q <= (serial_tx_data_line != line_q) ? 0 : (quiet_q < 100000 ? quiet_q + 1 : quiet_q);
    end
  end
  a_pause_early: assert property (quiet_q >= 4 && quiet_q < lim |-> !pause_det) else $error("early pause");
  a_pause_late: assert property (quiet_q == lim + 4 |-> pause_det) else $error("late pause");
  a_txoff_cond: assert property ($fell(radio_tx_on) |-> pause_det && !radio_out.valid)
    else $error("transmitter off too soon");
  a_rx_priority: assert property ($rose(radio_tx_on) |-> !$past(radio_rx_busy)) else $error("tx while busy");
  a_out_hold: assert property (radio_out.valid && !radio_ready |=> radio_out.valid && $stable(radio_out.data))
    else $error("radio byte not held");
  // The mode output lags the answer pulse by one cycle, so its change is seen one cycle later.
  a_cmd_ok_cause: assert property (cmd_ok |-> $past(char_in.valid)
    && $past(char_in.data) == (cmd_mode ? CHR_MINUS : CHR_PLUS) ##1 cmd_mode != $past(cmd_mode))
    else $error("bad command mode answer");
  a_cfg_cause: assert property (config_command_start |-> $past(char_in.valid) && (cmd_mode
    || $past(cfg.cfg_cmd_en) && $past(char_in.data) == CFG_LEAD_CHR)) else $error("bad command start");
  a_addr_cause: assert property (addr_start_seen |-> $past(char_in.valid) && !cmd_mode
    && $past(char_in.data) == $past(cfg.addr_char)) else $error("bad address start");
  a_overfill_cts: assert property (overfill_restart |-> !$past(cts)) else $error("overfill while clear");
endmodule : spf_framer_sva

bind spf_framer spf_framer_sva #(.CAP_CYCLES(CAP_CYCLES)) u_sva (.clk(clk), .reset_n(reset_n),
  .serial_tx_data_line(serial_tx_data_line), .char_in(char_in), .cfg(cfg), .radio_rx_busy(radio_rx_busy),
  .radio_ready(radio_ready), .radio_out(radio_out), .radio_tx_on(radio_tx_on), .cts(cts), .pause_det(pause_det),
  .cmd_mode(cmd_mode), .cmd_ok(cmd_ok), .config_command_start(config_command_start),
  .addr_start_seen(addr_start_seen), .overfill_restart(overfill_restart));

//--- verif/spf_term_model.sv
// Terminal model: toggles the serial data line and hands over characters.
module spf_term_model import spf_pkg::*; (
  input wire logic clk,
  input wire logic cts,
  output logic line,
  output spf_char_s chr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line = 1'b1;
    chr = '0;
  end
  always @(posedge clk) chr.valid <= 1'b0;
  // A rude terminal ignores clear-to-send so that overfill can be provoked.
  task automatic send(input logic [7:0] d, input bit rude);
    int w;
    w = 0;
    while (!rude && cts !== 1'b1 && w < 5000) begin
      @(posedge clk);
      #1 w++;
    end
    line = ~line;
    chr = '{valid: 1'b1, data: d};
    @(posedge clk);
    #1;
  endtask : send
endmodule : spf_term_model

//--- verif/tb_serial_pause_framer_tx_buffer.sv
// Self-checking bench for the pause framer and its transmit buffer.
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_serial_pause_framer_tx_buffer import spf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, busy, rdy, line, cts, tx_on, pdet, cmode, ok_p, cst_p, adr_p, ovf_p;
  spf_char_s chr, rout;
  spf_cfg_s cfg;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n_ok = 0, n_cst = 0, n_adr = 0, n_ovf = 0, n0, n1;
  logic [7:0] q[$];
  spf_framer #(.CAP_CYCLES(200), .PRE_CYCLES(8)) uut (.clk(clk), .reset_n(reset_n), .serial_tx_data_line(line),
    .char_in(chr), .cfg(cfg), .radio_rx_busy(busy), .radio_ready(rdy), .radio_out(rout), .radio_tx_on(tx_on),
    .cts(cts), .pause_det(pdet), .cmd_mode(cmode), .cmd_ok(ok_p), .config_command_start(cst_p),
    .addr_start_seen(adr_p), .overfill_restart(ovf_p));
  spf_term_model term (.clk(clk), .cts(cts), .line(line), .chr(chr));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (ok_p === 1'b1) n_ok++;
    if (cst_p === 1'b1) n_cst++;
    if (adr_p === 1'b1) n_adr++;
    if (ovf_p === 1'b1) n_ovf++;
    if (rout.valid === 1'b1 && rdy === 1'b1) q.push_back(rout.data);
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic t_pause();
    wt(50);
    `CHK("pause", 1'b0, pdet)
    wt(20);
    `CHK("pause", 1'b1, pdet)
    term.send(8'h01, 1'b0);
    cfg.pause_chars = 8'hff;
    wt(150);
    `CHK("pause", 1'b0, pdet)
    wt(60);
    `CHK("pause", 1'b1, pdet)
    cfg.pause_chars = PAUSE_DEF;
  endtask : t_pause
  task automatic t_cmd();
    wt(80);
    repeat (3) term.send(CHR_PLUS, 1'b0);
    wt(2);
    `CHK("cmd_mode", 1'b0, cmode)
    for (int k = 0; k < 2; k++) begin
      n0 = n_ok;
      repeat (3) begin
        wt(80);
        term.send(k ? CHR_MINUS : CHR_PLUS, 1'b0);
      end
      wt(2);
      `CHK("cmd_ok", n0 + 1, n_ok)
      `CHK("cmd_mode", k == 0, cmode)
    end
  endtask : t_cmd
  task automatic t_frame();
    n0 = n_cst;
    n1 = n_adr;
    wt(80);
    repeat (2) term.send(CFG_LEAD_CHR, 1'b0);
    wt(80);
    repeat (2) term.send(cfg.addr_char, 1'b0);
    wt(2);
    `CHK("cfg_start", n0 + 1, n_cst)
    `CHK("addr_start", n1 + 1, n_adr)
  endtask : t_frame
  task automatic t_data();
    wt(100);
    q.delete();
    rdy = 1'b0;
    for (int i = 1; i < 4; i++) term.send(8'h11 * i, 1'b0);
    `CHK("tx_on", 1'b1, tx_on)
    wt(20);
    `CHK("sent", 0, q.size())
    rdy = 1'b1;
    wt(20);
    `CHK("tx_on", 1'b1, tx_on)
    `CHK("sent", 3, q.size())
    for (int i = 0; i < 3; i++) `CHK("byte", 8'h11 * (i + 1), q[i])
    wt(40);
    `CHK("tx_on", 1'b0, tx_on)
  endtask : t_data
  task automatic t_rx();
    q.delete();
    busy = 1'b1;
    term.send(8'h44, 1'b0);
    term.send(8'h55, 1'b0);
    wt(100);
    `CHK("tx_on", 1'b0, tx_on)
    busy = 1'b0;
    wt(30);
    `CHK("sent", 2, q.size())
    `CHK("byte", 8'h55, q[1])
    wt(60);
  endtask : t_rx
  task automatic t_ovf();
    n0 = n_ovf;
    busy = 1'b1;
    for (int i = 0; i < 1024; i++) begin
      term.send(i[7:0], 1'b1);
      if (i == 1010) `CHK("cts", 1'b0, cts)
    end
    `CHK("overfill", n0, n_ovf)
    term.send(8'h99, 1'b1);
    wt(2);
    `CHK("overfill", n0 + 1, n_ovf)
    `CHK("cts", 1'b1, cts)
    busy = 1'b0;
    wt(100);
  endtask : t_ovf
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    busy = 1'b0;
    rdy = 1'b1;
    cfg = '{pause_chars: 8'h03, frame_bits: 4'ha, bit_cycles: 16'h0002, addr_char: 8'ha5, cfg_cmd_en: 1'b1};
    repeat (5) @(posedge clk);
    #1;
    `CHK("cts", 1'b1, cts)
    reset_n = 1'b1;
    t_pause();
    t_cmd();
    t_frame();
    t_data();
    t_rx();
    t_ovf();
    give_verdict();
  end
endmodule : tb_serial_pause_framer_tx_buffer
